//--- usbw_pkg.sv
// Constants and types shared by the serial port status, baud and wake-up block
package usbw_pkg;
  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_STATUS = 8'h50;
  localparam logic [7:0] IDX_DATA   = 8'h51;
  localparam logic [7:0] IDX_RATE   = 8'h52;
  localparam logic [7:0] IDX_FRAME  = 8'h53;
  localparam logic [7:0] IDX_IRQEN  = 8'h54;
  localparam logic [7:0] IDX_RXFINE = 8'h55;
  localparam logic [7:0] IDX_TXFINE = 8'h57;
  localparam int         ADDR_LSB   = 2;
  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int ST_TXE = 7, ST_TXDONE = 6, ST_RXFULL = 5, ST_IDLE = 4;
  localparam int ST_OVR = 3, ST_NOISE = 2, ST_FERR = 1;
  localparam int FC_RX9 = 7, FC_TX9 = 6, FC_LEN = 4, FC_WAKE = 3;
  localparam int IE_TXE = 7, IE_TXDONE = 6, IE_RX = 5, IE_IDLE = 4;
  localparam int IE_TXON = 3, IE_RXON = 2, IE_MUTE = 1, IE_BRK = 0;
  localparam int RS_PRE_HI = 7, RS_PRE_LO = 6;
  localparam int RS_TX_HI = 5, RS_TX_LO = 3, RS_RX_HI = 2, RS_RX_LO = 0;
  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] STATUS_RST = 8'hc0;
  localparam logic [7:0] FRAME_RST  = 8'h00;
  localparam logic [7:0] IRQEN_RST  = 8'h00;
  localparam logic [7:0] RATE_RST   = 8'h00;
  localparam logic [7:0] FINE_RST   = 8'h00;
  // ----------------------------------------------------------------------
  // Timing: fine rate = clk/(16*N), conventional = clk/(32*PR*2^n)
  // ----------------------------------------------------------------------
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned CONV_DIV   = 32;
  localparam int unsigned CONV_TICK  = CONV_DIV / OVERSAMPLE;
  localparam logic [3:0]  PR_CODE0 = 4'h1, PR_CODE1 = 4'h3;
  localparam logic [3:0]  PR_CODE2 = 4'h4, PR_CODE3 = 4'hd;
  localparam logic [3:0]  SMP_FIRST = 4'h7, SMP_MID = 4'h8, SMP_LAST = 4'h9;
  localparam logic [3:0]  SUB_END   = 4'hf;
  localparam logic [3:0]  BITS_SHORT = 4'ha, BITS_LONG = 4'hb;
  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [8:0] data;
    logic       noise;
    logic       frameErr;
  } usbw_rxword_t;
  typedef enum logic [1:0] {K_DATA, K_PREAMBLE, K_BREAK, K_TAIL} usbw_kind_t;
  typedef enum {TX_IDLE, TX_SHIFT} usbw_txst_t;
  typedef enum {RX_HUNT, RX_FRAME} usbw_rxst_t;
endpackage

//--- usbw_core.sv
// Serial port: status flags, baud generators, mute/wake-up, APB registers
`timescale 1ns/10ps
// Notes on behaviour
// - Missing stop bit at its sample time, or a received break, is a framing error.
// - Framing error sets its flag, still transfers the word, no own interrupt.
// - Conventional rate is clock over 32 times prescale times direction divisor.
// - Prescale divider is one of 1, 3, 4 or 13 from a two-bit field.
// - Prescale codes 00..11 give 1, 3, 4, 13; field at bits 7:6.
// - Each direction has a power-of-two divisor 1..128 from its own field.
// - Divisor code n divides by 2^n; transmit bits 5:3, receive 2:0.
// - Nonzero fine divisor N gives rate clock over 16 times N.
// - Conventional divisor applies only while that fine divisor is zero.
// - Muted receiver sets no receive status and raises no receive interrupt.
// - Mute ends on idle line if wake method 0, address mark if 1.
// - Idle wake-up clears mute in hardware without setting the idle flag.
// - Word with top bit one wakes the receiver and is received normally.
// - Holding-to-shift move sets buffer empty; status then write clears it.
// - End of data, preamble or break frame sets done; status then write clears.
// - Received word sets full; cleared by receive off or status then read.
// - Idle line sets idle flag once per received word; an idle wake-up defers it to the next idle tick.
// - Word finding full set sets overrun and keeps the held word.
// - Noise in a frame sets noise flag with full, no own interrupt.
// - Overrun plus framing error on one word sets only overrun.
// - Word length bit selects 8 or 9 data bits; ninth bits in frame control.
// - One interrupt line ORs each enabled flag pair.
// - Transmit enable owns the output pin; off-on pulse queues a preamble.
// - Receive off clears five receive flags; on starts hunting a start bit.
module usbw_core (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serialInPin,
  output logic             serialOutPin,
  output logic             serialOutEn,
  output logic             irq
);
  // ----------------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------------
  logic [7:0]  rate_q, frame_q, irqen_q, rxFine_q, txFine_q;
  logic        txEmpty_q, txDone_q, rxFull_q, idle_q, ovr_q, noise_q, ferr_q;
  logic [8:0]  rxHold_q, txHold_q;
  logic        armed_q, rxClrSnap_q;
  logic [4:0]  snap_q;
  logic [31:0] prdata_q;
  logic        pready_q, pslverr_q, serialOut_q, serialOutEn_q, irq_q;
  logic [1:0]  tick;
  logic [11:0] period [2];
  logic [3:0]  prFactor;
  logic        setupCyc, accessCyc, rdData, wrData, acStatus;
  logic [7:0]  idx;
  logic        txOn, rxOn, mute, wakeAddr, len9;

  assign idx       = paddr[usbw_pkg::ADDR_LSB+7:usbw_pkg::ADDR_LSB];
  assign setupCyc  = psel & ~penable;
  assign accessCyc = psel & penable & pready_q;
  assign acStatus  = accessCyc & (idx == usbw_pkg::IDX_STATUS);
  assign rdData    = accessCyc & ~pwrite & (idx == usbw_pkg::IDX_DATA);
  assign wrData    = accessCyc & pwrite & (idx == usbw_pkg::IDX_DATA);
  assign txOn      = irqen_q[usbw_pkg::IE_TXON];
  assign rxOn      = irqen_q[usbw_pkg::IE_RXON];
  assign mute      = irqen_q[usbw_pkg::IE_MUTE];
  assign wakeAddr  = frame_q[usbw_pkg::FC_WAKE];
  assign len9      = frame_q[usbw_pkg::FC_LEN];

  // ----------------------------------------------------------------------
  // Baud tick generators, one per direction (0 transmit, 1 receive)
  // ----------------------------------------------------------------------
  always_comb begin
    unique case (rate_q[usbw_pkg::RS_PRE_HI:usbw_pkg::RS_PRE_LO])
      2'b00: prFactor = usbw_pkg::PR_CODE0;
      2'b01: prFactor = usbw_pkg::PR_CODE1;
      2'b10: prFactor = usbw_pkg::PR_CODE2;
      2'b11: prFactor = usbw_pkg::PR_CODE3;
    endcase
  end

  for (genvar g = 0; g < 2; g++) begin : g_baud
    logic [7:0]  fine;
    logic [2:0]  pw;
    logic [11:0] cnt_q;
    assign fine = (g == 0) ? txFine_q : rxFine_q;
    assign pw   = (g == 0) ? rate_q[usbw_pkg::RS_TX_HI:usbw_pkg::RS_TX_LO]
                           : rate_q[usbw_pkg::RS_RX_HI:usbw_pkg::RS_RX_LO];
    // Fine divisor counts 16x ticks directly; conventional has the extra /2
    assign period[g] = (fine != 8'h00) ? {4'h0, fine}
                     : 12'((usbw_pkg::CONV_TICK * prFactor) << pw);
    assign tick[g] = (cnt_q == 12'h000);
    always_ff @(posedge sys_clk) begin
      if (sys_rst || !((g == 0) ? txOn : rxOn)) begin
        cnt_q <= 12'h000;
      end else if (tick[g]) begin
        cnt_q <= period[g] - 12'h001;
      end else begin
        cnt_q <= cnt_q - 12'h001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Transmit engine
  // ----------------------------------------------------------------------
  usbw_pkg::usbw_txst_t txSt_q;
  usbw_pkg::usbw_kind_t txKind_q;
  logic [10:0] txShift_q;
  logic [3:0]  txSub_q, txLeft_q;
  logic        txOnDly_q, preamble_q, brkTail_q, txLoadData, txFrameEnd;

  assign txLoadData = (txSt_q == usbw_pkg::TX_IDLE) & txOn & ~preamble_q
                    & ~irqen_q[usbw_pkg::IE_BRK] & ~brkTail_q & ~txEmpty_q;
  assign txFrameEnd = (txSt_q == usbw_pkg::TX_SHIFT) & tick[0] & (txLeft_q == 4'h1)
                    & (txSub_q == usbw_pkg::SUB_END);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      txOnDly_q  <= 1'b0;
      preamble_q <= 1'b0;
    end else begin
      txOnDly_q <= txOn;
      if (txOn && !txOnDly_q) begin
        preamble_q <= 1'b1;
      end else if (txSt_q == usbw_pkg::TX_IDLE && txOn && preamble_q) begin
        preamble_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || !txOn) begin
      txSt_q    <= usbw_pkg::TX_IDLE;
      txKind_q  <= usbw_pkg::K_DATA;
      txShift_q <= '1;
      txSub_q   <= 4'h0;
      txLeft_q  <= 4'h0;
      brkTail_q <= 1'b0;
    end else if (txSt_q == usbw_pkg::TX_IDLE) begin
      txSub_q <= 4'h0;
      txLeft_q <= len9 ? usbw_pkg::BITS_LONG : usbw_pkg::BITS_SHORT;
      if (preamble_q) begin
        txSt_q <= usbw_pkg::TX_SHIFT;
        txKind_q <= usbw_pkg::K_PREAMBLE;
        txShift_q <= '1;
      end else if (irqen_q[usbw_pkg::IE_BRK]) begin
        txSt_q <= usbw_pkg::TX_SHIFT;
        txKind_q <= usbw_pkg::K_BREAK;
        txShift_q <= '0;
      end else if (brkTail_q) begin
        // A lone high bit after the last break so a start bit can be seen
        txSt_q <= usbw_pkg::TX_SHIFT;
        txKind_q <= usbw_pkg::K_TAIL;
        txShift_q <= '1;
        txLeft_q <= 4'h1;
        brkTail_q <= 1'b0;
      end else if (txLoadData) begin
        txSt_q <= usbw_pkg::TX_SHIFT;
        txKind_q <= usbw_pkg::K_DATA;
        txShift_q <= len9 ? {1'b1, txHold_q, 1'b0} : {2'b11, txHold_q[7:0], 1'b0};
      end
    end else if (tick[0]) begin
      txSub_q <= txSub_q + 4'h1;
      if (txSub_q == usbw_pkg::SUB_END) begin
        txShift_q <= {1'b1, txShift_q[10:1]};
        txLeft_q <= txLeft_q - 4'h1;
        if (txLeft_q == 4'h1) begin
          txSt_q <= usbw_pkg::TX_IDLE;
          brkTail_q <= (txKind_q == usbw_pkg::K_BREAK) & ~irqen_q[usbw_pkg::IE_BRK];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Receive engine
  // ----------------------------------------------------------------------
  usbw_pkg::usbw_rxst_t rxSt_q;
  usbw_pkg::usbw_rxword_t rxWord;
  logic       rxIn_q, rxNoise_q, rxDoneEv, idleEv, maj, disagree, rxBitAt;
  logic [1:0] rxSmp_q;
  logic [3:0] rxSub_q, rxBit_q;
  logic [8:0] rxShift_q;
  logic [7:0] idleCnt_q;

  assign maj      = (rxSmp_q[0] & rxSmp_q[1]) | (rxSmp_q[0] & rxIn_q)
                  | (rxSmp_q[1] & rxIn_q);
  assign disagree = ~((rxSmp_q[0] == rxSmp_q[1]) & (rxSmp_q[1] == rxIn_q));
  assign rxBitAt  = (rxSt_q == usbw_pkg::RX_FRAME) & tick[1]
                  & (rxSub_q == usbw_pkg::SMP_LAST);
  assign rxDoneEv = rxBitAt & (rxBit_q == (len9 ? 4'ha : 4'h9));
  assign rxWord.data     = len9 ? rxShift_q : {1'b0, rxShift_q[8:1]};
  assign rxWord.noise    = rxNoise_q | disagree;
  assign rxWord.frameErr = ~maj;
  assign idleEv = (rxSt_q == usbw_pkg::RX_HUNT) & tick[1] & rxIn_q
                & (idleCnt_q == 8'((len9 ? usbw_pkg::BITS_LONG : usbw_pkg::BITS_SHORT)
                                   * usbw_pkg::OVERSAMPLE - 1));

  always_ff @(posedge sys_clk) begin
    if (sys_rst || !rxOn) begin
      rxIn_q    <= 1'b1;
      rxSt_q    <= usbw_pkg::RX_HUNT;
      rxSub_q   <= 4'h0;
      rxBit_q   <= 4'h0;
      rxSmp_q   <= 2'b11;
      rxShift_q <= 9'h000;
      rxNoise_q <= 1'b0;
      idleCnt_q <= 8'h00;
    end else begin
      rxIn_q <= serialInPin;
      if (rxSt_q == usbw_pkg::RX_HUNT) begin
        if (tick[1]) begin
          idleCnt_q <= !rxIn_q ? 8'h00 : (idleEv || idleCnt_q == 8'hff) ? idleCnt_q
                                        : idleCnt_q + 8'h01;
          if (!rxIn_q) begin
            rxSt_q <= usbw_pkg::RX_FRAME;
            rxSub_q <= 4'h0;
            rxBit_q <= 4'h0;
            rxNoise_q <= 1'b0;
          end
        end
      end else if (tick[1]) begin
        rxSub_q <= rxSub_q + 4'h1;
        if (rxSub_q == usbw_pkg::SMP_FIRST || rxSub_q == usbw_pkg::SMP_MID) begin
          rxSmp_q <= {rxSmp_q[0], rxIn_q};
        end
        if (rxBitAt) begin
          rxNoise_q <= rxNoise_q | disagree;
          rxBit_q <= rxBit_q + 4'h1;
          if (rxBit_q != 4'h0) begin
            rxShift_q <= {maj, rxShift_q[8:1]};
          end
          if ((rxBit_q == 4'h0 && maj) || rxDoneEv) begin
            rxSt_q <= usbw_pkg::RX_HUNT;
            idleCnt_q <= 8'h00;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Status flags; a hardware set always wins over a software clear
  // ----------------------------------------------------------------------
  logic rxAccept, rxOverrun, wakeByAddr, clr;
  logic idleArm_q;
  assign wakeByAddr = mute & wakeAddr & rxDoneEv & rxShift_q[8];
  assign rxAccept  = rxDoneEv & (~mute | wakeByAddr) & ~rxFull_q;
  assign rxOverrun = rxDoneEv & (~mute | wakeByAddr) & rxFull_q;
  assign clr       = rdData & rxClrSnap_q;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      txEmpty_q <= usbw_pkg::STATUS_RST[usbw_pkg::ST_TXE];
      txDone_q  <= usbw_pkg::STATUS_RST[usbw_pkg::ST_TXDONE];
    end else begin
      // Dropping the transmitter discards any held word
      txEmpty_q <= txLoadData | ~txOn | (txEmpty_q & ~(wrData & armed_q));
      txDone_q  <= (txFrameEnd & (txKind_q != usbw_pkg::K_TAIL))
                 | (txDone_q & ~(wrData & armed_q));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || !rxOn) begin
      rxFull_q  <= 1'b0;
      idle_q    <= 1'b0;
      ovr_q     <= 1'b0;
      noise_q   <= 1'b0;
      ferr_q    <= 1'b0;
      idleArm_q <= 1'b0;
    end else begin
      rxFull_q <= rxAccept | (rxFull_q & ~(clr & snap_q[4]));
      ovr_q    <= rxOverrun | (ovr_q & ~(clr & snap_q[3]));
      noise_q  <= (rxAccept & rxWord.noise) | (noise_q & ~(clr & snap_q[2]));
      ferr_q   <= (rxAccept & rxWord.frameErr) | (ferr_q & ~(clr & snap_q[1]));
      idle_q   <= (idleEv & ~mute & idleArm_q) | (idle_q & ~(clr & snap_q[0]));
      if (rxAccept) begin
        idleArm_q <= 1'b1;
      end else if (idleEv && !mute) begin
        idleArm_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rxHold_q <= 9'h000;
    end else if (rxAccept) begin
      rxHold_q <= rxWord.data;
    end
  end

  // ----------------------------------------------------------------------
  // APB slave: one-cycle access phase, registered answer
  // ----------------------------------------------------------------------
  logic [7:0] statusVal, rdVal;
  logic       mapped;
  assign statusVal = {txEmpty_q, txDone_q, rxFull_q, idle_q, ovr_q, noise_q, ferr_q, 1'b0};
  always_comb begin
    mapped = 1'b1;
    unique case (idx)
      usbw_pkg::IDX_STATUS: rdVal = statusVal;
      usbw_pkg::IDX_DATA:   rdVal = rxHold_q[7:0];
      usbw_pkg::IDX_RATE:   rdVal = rate_q;
      usbw_pkg::IDX_FRAME:  rdVal = {rxHold_q[8], frame_q[6:0]};
      usbw_pkg::IDX_IRQEN:  rdVal = irqen_q;
      usbw_pkg::IDX_RXFINE: rdVal = rxFine_q;
      usbw_pkg::IDX_TXFINE: rdVal = txFine_q;
      default: begin
        rdVal = 8'h00;
        mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready_q    <= 1'b0;
      pslverr_q   <= 1'b0;
      prdata_q    <= 32'h0000_0000;
      armed_q     <= 1'b0;
      rxClrSnap_q <= 1'b0;
      snap_q      <= 5'h00;
    end else begin
      pready_q  <= setupCyc;
      pslverr_q <= setupCyc & (~mapped | (paddr[1:0] != 2'b00));
      prdata_q  <= setupCyc ? {24'h000000, rdVal} : 32'h0000_0000;
      // Only flags already shown by the snapshot may be cleared by the read
      if (setupCyc) begin
        rxClrSnap_q <= armed_q;
        snap_q      <= {rxFull_q, ovr_q, noise_q, ferr_q, idle_q};
      end
      if (acStatus) begin
        armed_q <= 1'b1;
      end else if (rdData || wrData) begin
        armed_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rate_q   <= usbw_pkg::RATE_RST;
      frame_q  <= usbw_pkg::FRAME_RST;
      irqen_q  <= usbw_pkg::IRQEN_RST;
      rxFine_q <= usbw_pkg::FINE_RST;
      txFine_q <= usbw_pkg::FINE_RST;
      txHold_q <= 9'h000;
    end else begin
      if (accessCyc && pwrite) begin
        unique case (idx)
          usbw_pkg::IDX_RATE:   rate_q <= pwdata[7:0];
          usbw_pkg::IDX_FRAME:  frame_q <= {1'b0, pwdata[6], 1'b0, pwdata[4:3], 3'b000};
          usbw_pkg::IDX_RXFINE: rxFine_q <= pwdata[7:0];
          usbw_pkg::IDX_TXFINE: txFine_q <= pwdata[7:0];
          usbw_pkg::IDX_DATA:   txHold_q <= {frame_q[usbw_pkg::FC_TX9], pwdata[7:0]};
          default: ;
        endcase
      end
      if (accessCyc && pwrite && idx == usbw_pkg::IDX_IRQEN) begin
        irqen_q <= pwdata[7:0];
      end else if (mute && ((idleEv && !wakeAddr) || wakeByAddr)) begin
        irqen_q[usbw_pkg::IE_MUTE] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pins and interrupt
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      serialOut_q   <= 1'b1;
      serialOutEn_q <= 1'b0;
      irq_q         <= 1'b0;
    end else begin
      serialOutEn_q <= txOn;
      // Gate with the enable so a frame cut by a disable never leaves the pin low
      serialOut_q   <= (txOn && txSt_q == usbw_pkg::TX_SHIFT) ? txShift_q[0] : 1'b1;
      irq_q <= (txEmpty_q & irqen_q[usbw_pkg::IE_TXE])
             | (txDone_q & irqen_q[usbw_pkg::IE_TXDONE])
             | ((ovr_q | rxFull_q) & irqen_q[usbw_pkg::IE_RX] & ~mute)
             | (idle_q & irqen_q[usbw_pkg::IE_IDLE] & ~mute);
    end
  end

  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign serialOutPin = serialOut_q;
  assign serialOutEn  = serialOutEn_q;
  assign irq          = irq_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_fe_with_full: assert property (rxDoneEv && !mute && !rxFull_q && !maj
    |=> rxFull_q && ferr_q && rxHold_q == $past(rxWord.data)) else $error("framing word lost");
  a_overrun_only: assert property (rxOverrun && !(rdData && rxClrSnap_q)
    |=> ovr_q && rxHold_q == $past(rxHold_q) && $stable(ferr_q)) else $error("overrun handling");
  a_rx_off_clear: assert property (!rxOn |=> !rxFull_q && !idle_q && !ovr_q
    && !noise_q && !ferr_q) else $error("receive flags kept");
  a_irq_terms: assert property (##1 irq_q == $past((txEmpty_q && irqen_q[7])
    || (txDone_q && irqen_q[6]) || ((ovr_q || rxFull_q) && irqen_q[5] && !mute)
    || (idle_q && irqen_q[4] && !mute))) else $error("interrupt mismatch");
  a_pin_owned: assert property (!txOn |=> !serialOutEn ##0 serialOutPin)
    else $error("pin driven while off");
  a_mute_silent: assert property (mute && rxDoneEv && !wakeByAddr && !rxFull_q
    |=> !rxFull_q) else $error("muted receiver flagged");
  a_idle_wake: assert property (mute && !wakeAddr && idleEv && !idle_q
    |=> !mute && !idle_q) else $error("idle wake-up wrong");
  a_addr_wake: assert property (wakeByAddr && !rxFull_q |=> !mute && rxFull_q)
    else $error("address wake-up wrong");
  a_conv_period: assert property (txFine_q == 8'h00 |-> period[0] ==
    12'(2 * (prFactor == 4'hd ? 13 : prFactor == 4'h4 ? 4 : prFactor == 4'h3 ? 3 : 1)
    * (1 << rate_q[5:3]))) else $error("conventional divisor wrong");
  a_fine_period: assert property (tick[1] && rxFine_q != 8'h00 && rxOn && $stable(rxFine_q)
    |=> !tick[1] [*1] or rxFine_q == 8'h01) else $error("fine divisor wrong");
  a_word_len: assert property (txLoadData |=> txLeft_q == (len9 ? 4'hb : 4'ha))
    else $error("frame length wrong");
  a_tx_empty_set: assert property (txLoadData |=> txEmpty_q) else $error("empty not set");

  c_rx_word: cover property (rxAccept ##[1:1000] rdData);
  c_overrun: cover property (rxOverrun);
  c_break_tail: cover property (txKind_q == usbw_pkg::K_TAIL && txFrameEnd);
  c_wake_addr: cover property (wakeByAddr);
endmodule // usbw_core

//--- usbw_partner.sv
// Remote serial sender that drives the receive line of the port
`timescale 1ns/10ps
module usbw_partner (
  input  wire logic sys_clk,
  output logic      serialLine
);
  initial serialLine = 1'b1;
  // -------------------------------------------------------------------
  // Frame sender
  // -------------------------------------------------------------------
  // Start low, data LSB first, stop bit, then one idle bit so the line
  // is high again before the next call
  task automatic sendWord(input logic [8:0] w, input int nBits, input int per,
                          input logic stopBit);
    for (int i = 0; i < nBits + 3; i++) begin
      @(posedge sys_clk);
      serialLine <= (i == 0) ? 1'b0 : (i <= nBits) ? w[i-1] :
                    (i == nBits + 1) ? stopBit : 1'b1;
      repeat (per - 1) @(posedge sys_clk);
    end
  endtask
endmodule // usbw_partner

//--- usbw_core_tb_top.sv
// Self-checking bench for the serial port status, baud and wake-up block
`timescale 1ns/10ps
module usbw_core_tb_top;
  localparam logic [7:0] aSt = usbw_pkg::IDX_STATUS;
  localparam logic [7:0] aDat = usbw_pkg::IDX_DATA;
  localparam logic [7:0] aIe = usbw_pkg::IDX_IRQEN;
  localparam logic [7:0] aFr = usbw_pkg::IDX_FRAME;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, serialInPin, serialOutPin, serialOutEn, irq, err;
  int          failCount = 0;
  int          totalChecks = 0;
  int          cycles = 0;
  int          prTab[4] = '{1, 3, 4, 13};
  usbw_core dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .serialInPin(serialInPin),
    .serialOutPin(serialOutPin), .serialOutEn(serialOutEn), .irq(irq));
  usbw_partner u (.sys_clk(sys_clk), .serialLine(serialInPin));
  always #5 sys_clk = ~sys_clk;
  // Longest run is well under this many cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failCount++;
      testDone();
    end
  end
  // -------------------------------------------------------------------
  // Bus and check tasks
  // -------------------------------------------------------------------
  task automatic testDone();
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h0, d});
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, {24'h0, exp});
  endtask
  // -------------------------------------------------------------------
  // Tests
  // -------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rdchk(aSt, 8'hc0);
    rdchk(usbw_pkg::IDX_TXFINE, 8'h00);
    apb(1'b0, 8'h56, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(aIe, 8'h88);
    repeat (2) @(posedge sys_clk);
    chk({30'h0, irq, serialOutEn}, 32'h3);
    chk({31'h0, serialOutPin}, 32'h1);
    $display("test registers done");
    wr(aIe, 8'h00);
    wr(usbw_pkg::IDX_RXFINE, 8'h01);
    wr(aIe, 8'h24);
    u.sendWord(9'h0a5, 8, 16, 1'b1);
    rdchk(aSt, 8'he0);
    chk({31'h0, irq}, 32'h1);
    rdchk(aDat, 8'ha5);
    u.sendWord(9'h03c, 8, 16, 1'b1);
    u.sendWord(9'h055, 8, 16, 1'b0);
    rdchk(aSt, 8'he8);
    wr(aIe, 8'h00);
    rdchk(aSt, 8'hc0);
    rdchk(aDat, 8'h3c);
    wr(aIe, 8'h04);
    u.sendWord(9'h000, 8, 16, 1'b0);
    rdchk(aSt, 8'he2);
    rdchk(aDat, 8'h00);
    rdchk(aSt, 8'hc0);
    $display("test errors done");
    wr(aFr, 8'h08);
    wr(aIe, 8'h26);
    u.sendWord(9'h012, 8, 16, 1'b1);
    rdchk(aSt, 8'hc0);
    chk({31'h0, irq}, 32'h0);
    u.sendWord(9'h092, 8, 16, 1'b1);
    rdchk(aSt, 8'he0);
    rdchk(aDat, 8'h92);
    $display("test mute done");
    wr(aIe, 8'h00);
    wr(usbw_pkg::IDX_RXFINE, 8'h00);
    for (int p = 0; p < 4; p++) begin
      wr(aIe, 8'h00);
      wr(usbw_pkg::IDX_RATE, {p[1:0], 3'b000, 3'(3 - p)});
      wr(aFr, {3'b000, p[0], 4'h0});
      wr(aIe, 8'h04);
      u.sendWord({p[0], 8'h5a}, 8 + p[0], 32 * prTab[p] * (1 << (3 - p)), 1'b1);
      rdchk(aSt, 8'he0);
      rdchk(aFr, {p[0], 2'b00, p[0], 4'h0});
      rdchk(aDat, 8'h5a);
    end
    $display("test rates done");
    testDone();
  end
endmodule // usbw_core_tb_top
